// ===== mmd_access_params.svh
// Offsets, field positions, codes and bit counts of the indirect access block
`ifndef MMD_ACCESS_PARAMS_SVH
`define MMD_ACCESS_PARAMS_SVH

`define ACC_CTRL_OFFSET     5'h0d
`define ADDR_DATA_OFFSET    5'h0e
`define ACC_CTRL_RESET      16'h0000
`define EXT_ADDR_RESET      16'h0000

`define FUNC_MSB            15
`define FUNC_LSB            14
`define SPACE_MSB           4
`define SPACE_LSB           0

`define FUNC_ADDR           2'h0
`define FUNC_DATA           2'h1
`define FUNC_INC_RW         2'h2
`define FUNC_INC_WR         2'h3

`define SPACE_CODE_PRIMARY  5'h1f
`define SPACE_CODE_PMA      5'h01
`define SPACE_CODE_VA       5'h03
`define SPACE_CODE_VB       5'h07

`define OP_READ             2'h2
`define OP_WRITE            2'h1
`define HDR_BITS            5'h0c
`define TA_BITS             5'h02
`define DATA_BITS           5'h10
`define SKIP_BITS           5'h12

`endif

// ===== mmd_access_pkg.sv
// Types and space decoding shared by the indirect access block
`include "mmd_access_params.svh"

package mmd_access_pkg;

    typedef enum logic [1:0] {
        SPACE_PRIMARY,
        SPACE_PMA,
        SPACE_VENDOR_A,
        SPACE_VENDOR_B
    } space_e;

    typedef enum logic [2:0] {
        FR_SEEK,
        FR_START,
        FR_HEADER,
        FR_READ_TA,
        FR_READ_DATA,
        FR_WRITE_TA,
        FR_WRITE_DATA,
        FR_SKIP
    } frame_state_e;

    // Only four select codes open a space
    function automatic logic spaceOk(input logic [4:0] code);
        case (code)
            `SPACE_CODE_PRIMARY,
            `SPACE_CODE_PMA,
            `SPACE_CODE_VA,
            `SPACE_CODE_VB: spaceOk = 1'b1; // R3 R4 R5
            default:        spaceOk = 1'b0; // R7
        endcase
    endfunction : spaceOk

    function automatic space_e spaceOf(input logic [4:0] code);
        case (code)
            `SPACE_CODE_PMA: spaceOf = SPACE_PMA;      // R4
            `SPACE_CODE_VA:  spaceOf = SPACE_VENDOR_A; // R5
            `SPACE_CODE_VB:  spaceOf = SPACE_VENDOR_B; // R5
            default:         spaceOf = SPACE_PRIMARY;  // R3
        endcase
    endfunction : spaceOf

endpackage : mmd_access_pkg

// ===== ext_pointer.sv
// Sixteen-bit extended address pointer with load and post increment
`timescale 1ns/1ns
`default_nettype none
`include "mmd_access_params.svh"

module ext_pointer
    import mmd_access_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic [15:0] loadVal,
    input  wire logic        inc,
    output var  logic [15:0] ptr_r
);

    logic [15:0] ptr_nxt;

    always_comb begin
        ptr_nxt = ptr_r;
        if (load) begin
            ptr_nxt = loadVal; // R9
        end else if (inc) begin
            // Natural carry out drops, so the top address wraps to zero
            ptr_nxt = ptr_r + 16'h0001; // R21
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ptr_r <= `EXT_ADDR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

endmodule : ext_pointer

`default_nettype wire

// ===== mdio_frame.sv
// Serial management frame receiver and read data shifter
`timescale 1ns/1ns
`default_nettype none
`include "mmd_access_params.svh"

module mdio_frame
    import mmd_access_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    input  wire logic [4:0]  phyAddr,
    input  wire logic [15:0] rdData,
    output var  logic        mdioOut_r,
    output var  logic        mdioOe_r,
    output var  logic        frmRd_r,
    output var  logic        frmWr_r,
    output var  logic [4:0]  frmReg_r,
    output var  logic [15:0] frmWrData_r
);

    frame_state_e state_r;
    frame_state_e state_nxt;
    logic         mdcPrev_r;
    logic         prevOne_r;
    logic         prevOne_nxt;
    logic [4:0]   cnt_r;
    logic [4:0]   cnt_nxt;
    logic [15:0]  sh_r;
    logic [15:0]  sh_nxt;
    logic         mdioOut_nxt;
    logic         mdioOe_nxt;
    logic         frmRd_nxt;
    logic         frmWr_nxt;
    logic [4:0]   frmReg_nxt;
    logic [15:0]  frmWrData_nxt;
    logic         rise;
    logic [15:0]  hdr;

    // Clock pin is sampled; management clock must stay at or below half of core_clk
    assign rise = mdc & ~mdcPrev_r;
    assign hdr  = {sh_r[14:0], mdioIn};

    always_comb begin
        state_nxt     = state_r;
        prevOne_nxt   = prevOne_r;
        cnt_nxt       = cnt_r;
        sh_nxt        = sh_r;
        mdioOut_nxt   = mdioOut_r;
        mdioOe_nxt    = mdioOe_r;
        frmRd_nxt     = 1'b0;
        frmWr_nxt     = 1'b0;
        frmReg_nxt    = frmReg_r;
        frmWrData_nxt = frmWrData_r;
        if (rise) begin
            cnt_nxt = cnt_r + 5'h01;
            case (state_r)
                FR_SEEK: begin
                    prevOne_nxt = mdioIn;
                    if (prevOne_r && !mdioIn) begin
                        state_nxt = FR_START; // R19
                    end
                end
                FR_START: begin
                    cnt_nxt     = 5'h00;
                    prevOne_nxt = mdioIn;
                    state_nxt   = mdioIn ? FR_HEADER : FR_SEEK; // R19
                end
                FR_HEADER: begin
                    sh_nxt = hdr;
                    if (cnt_r == `HDR_BITS - 5'h01) begin
                        cnt_nxt    = 5'h00;
                        frmReg_nxt = hdr[4:0]; // R18
                        if (hdr[9:5] != phyAddr) begin
                            state_nxt = FR_SKIP;
                        end else if (hdr[11:10] == `OP_READ) begin
                            frmRd_nxt = 1'b1;
                            state_nxt = FR_READ_TA;
                        end else if (hdr[11:10] == `OP_WRITE) begin
                            state_nxt = FR_WRITE_TA;
                        end else begin
                            state_nxt = FR_SKIP;
                        end
                    end
                end
                FR_READ_TA: begin
                    // First turnaround bit is left undriven, zero goes on the second
                    cnt_nxt     = 5'h00;
                    mdioOe_nxt  = 1'b1;
                    mdioOut_nxt = 1'b0;
                    state_nxt   = FR_READ_DATA;
                end
                FR_READ_DATA: begin
                    if (cnt_r == `DATA_BITS) begin
                        mdioOe_nxt  = 1'b0;
                        prevOne_nxt = 1'b0;
                        state_nxt   = FR_SEEK;
                    end else if (cnt_r == 5'h00) begin
                        mdioOut_nxt = rdData[15];
                        sh_nxt      = {rdData[14:0], 1'b0};
                    end else begin
                        mdioOut_nxt = sh_r[15];
                        sh_nxt      = {sh_r[14:0], 1'b0};
                    end
                end
                FR_WRITE_TA: begin
                    if (cnt_r == `TA_BITS - 5'h01) begin
                        cnt_nxt   = 5'h00;
                        state_nxt = FR_WRITE_DATA;
                    end
                end
                FR_WRITE_DATA: begin
                    sh_nxt = hdr;
                    if (cnt_r == `DATA_BITS - 5'h01) begin
                        frmWr_nxt     = 1'b1;
                        frmWrData_nxt = hdr;
                        prevOne_nxt   = 1'b0;
                        state_nxt     = FR_SEEK;
                    end
                end
                FR_SKIP: begin
                    // Frames for other addresses are counted out so data is not seen as a start
                    if (cnt_r == `SKIP_BITS - 5'h01) begin
                        prevOne_nxt = 1'b0;
                        state_nxt   = FR_SEEK;
                    end
                end
                default: begin
                    mdioOe_nxt = 1'b0;
                    state_nxt  = FR_SEEK;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_r     <= FR_SEEK;
            mdcPrev_r   <= 1'b0;
            prevOne_r   <= 1'b0;
            cnt_r       <= 5'h00;
            sh_r        <= 16'h0000;
            mdioOut_r   <= 1'b0;
            mdioOe_r    <= 1'b0;
            frmRd_r     <= 1'b0;
            frmWr_r     <= 1'b0;
            frmReg_r    <= 5'h00;
            frmWrData_r <= 16'h0000;
        end else begin
            state_r     <= state_nxt;
            mdcPrev_r   <= mdc;
            prevOne_r   <= prevOne_nxt;
            cnt_r       <= cnt_nxt;
            sh_r        <= sh_nxt;
            mdioOut_r   <= mdioOut_nxt;
            mdioOe_r    <= mdioOe_nxt;
            frmRd_r     <= frmRd_nxt;
            frmWr_r     <= frmWr_nxt;
            frmReg_r    <= frmReg_nxt;
            frmWrData_r <= frmWrData_nxt;
        end
    end

endmodule : mdio_frame

`default_nettype wire

// ===== mmd_indirect_register_access.sv
// Indirect extended register access behind the serial management pins
//
// Overview of operation
// [R1] Access-control register sits at direct address 0x0D, address/data at 0x0E.
// [R2] Access-control bits 4:0 select the extended space for address/data accesses.
// [R3] Select 11111 reaches the primary space, addresses up to 0x0EFD.
// [R4] Select 00001 reaches the medium attachment space, numbered to 0x1904.
// [R5] Select 00011 reaches vendor space A, 00111 reaches vendor space B.
// [R6] Station writes addresses without the top hex digit naming the space.
// [R7] Address/data accesses under any other select code are ignored.
// [R8] Access-control bits 15:14 pick address, data, increment-all or increment-on-write.
// [R9] Function 00: address/data reads and loads the extended address pointer.
// [R10] Function 01: access pointed register, pointer stays unchanged.
// [R11] Function 10: access pointed register, pointer increments after reads and writes.
// [R12] Function 11: pointer increments after writes only, not after reads.
// [R13] Station loads the pointer before any data access.
// [R14] Single write: function 00, address, function 01, data, in order.
// [R15] Station may skip address setup when the pointer already holds it.
// [R16] Burst writes use function 10 or 11, landing in successive registers.
// [R17] Burst reads use function 10, returning successive registers.
// [R18] Frame register field gives the direct register number, 32 registers.
// [R19] A frame begins with start pattern 01 after the idle line.
// [R20] Access-control bits 13:5 read zero, writes ignored; pointer is 16 bits.
// [R21] Pointer wraps to zero past its top value, nothing else happens.
`timescale 1ns/1ns
`default_nettype none
`include "mmd_access_params.svh"

module mmd_indirect_register_access
    import mmd_access_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output var  logic        mdioOut,
    output var  logic        mdioOe,
    input  wire logic [4:0]  phyAddr,
    output var  space_e      extSpace,
    output var  logic [15:0] extAddr,
    output var  logic [15:0] extWrData,
    output var  logic        extWr,
    output var  logic        extRd,
    input  wire logic [15:0] extRdData
);

    logic        frmRd;
    logic        frmWr;
    logic [4:0]  frmReg;
    logic [15:0] frmWrData;
    logic [15:0] ptr;

    logic [1:0]  func_r;
    logic [1:0]  func_nxt;
    logic [4:0]  space_r;
    logic [4:0]  space_nxt;
    logic [15:0] rdData_r;
    logic [15:0] rdData_nxt;
    logic        extWr_r;
    logic        extWr_nxt;
    logic        extRd_r;
    logic        extRd_nxt;
    logic [15:0] extWrData_r;
    logic [15:0] extWrData_nxt;
    space_e      extSpace_r;
    space_e      extSpace_nxt;
    logic        incDone_r;
    logic        incDone_nxt;
    logic        ptrLoad;
    logic        ptrInc;
    logic        isCtrl;
    logic        isData;
    logic        spaceGood;

    mdio_frame u_frame (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .mdc         (mdc),
        .mdioIn      (mdioIn),
        .phyAddr     (phyAddr),
        .rdData      (rdData_r),
        .mdioOut_r   (mdioOut),
        .mdioOe_r    (mdioOe),
        .frmRd_r     (frmRd),
        .frmWr_r     (frmWr),
        .frmReg_r    (frmReg),
        .frmWrData_r (frmWrData)
    );

    ext_pointer u_pointer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (ptrLoad),
        .loadVal  (frmWrData),
        .inc      (ptrInc),
        .ptr_r    (ptr)
    );

    assign isCtrl    = (frmReg == `ACC_CTRL_OFFSET);  // R1
    assign isData    = (frmReg == `ADDR_DATA_OFFSET); // R1
    assign spaceGood = spaceOk(space_r);              // R7

    // Pointer holds only the in-space offset, the space travels beside it
    assign extAddr   = ptr; // R6
    assign extSpace  = extSpace_r;
    assign extWrData = extWrData_r;
    assign extWr     = extWr_r;
    assign extRd     = extRd_r;

    // Address function writes load the pointer; ignored under a bad select
    assign ptrLoad = frmWr && isData && spaceGood && func_r == `FUNC_ADDR; // R9 R7

    // Increment lands on the edge that closes the access cycle
    assign ptrInc = (extWr_r || extRd_r) && incDone_r; // R11 R12

    always_comb begin
        func_nxt      = func_r;
        space_nxt     = space_r;
        rdData_nxt    = rdData_r;
        extWr_nxt     = 1'b0;
        extRd_nxt     = 1'b0;
        extWrData_nxt = extWrData_r;
        extSpace_nxt  = extSpace_r;
        incDone_nxt   = incDone_r;

        // Read data is captured while the external strobe is high
        if (extRd_r) begin
            rdData_nxt = extRdData;
        end

        if (frmWr) begin
            if (isCtrl) begin
                // Middle bits are not stored, so they read back as zero
                func_nxt  = frmWrData[`FUNC_MSB:`FUNC_LSB];   // R8 R20
                space_nxt = frmWrData[`SPACE_MSB:`SPACE_LSB]; // R2
            end else if (isData && spaceGood && func_r != `FUNC_ADDR) begin
                extWr_nxt     = 1'b1; // R10
                extWrData_nxt = frmWrData;
                extSpace_nxt  = spaceOf(space_r); // R2
                incDone_nxt   = (func_r == `FUNC_INC_RW) || (func_r == `FUNC_INC_WR); // R11 R12
            end
        end

        if (frmRd) begin
            rdData_nxt = 16'h0000;
            if (isCtrl) begin
                rdData_nxt = {func_r, 9'h000, space_r}; // R20
            end else if (isData && spaceGood) begin
                case (func_r)
                    `FUNC_ADDR: begin
                        rdData_nxt = ptr; // R9
                    end
                    `FUNC_DATA: begin
                        extRd_nxt    = 1'b1; // R10
                        extSpace_nxt = spaceOf(space_r);
                        incDone_nxt  = 1'b0;
                    end
                    `FUNC_INC_RW: begin
                        extRd_nxt    = 1'b1;
                        extSpace_nxt = spaceOf(space_r);
                        incDone_nxt  = 1'b1; // R11
                    end
                    `FUNC_INC_WR: begin
                        extRd_nxt    = 1'b1;
                        extSpace_nxt = spaceOf(space_r);
                        incDone_nxt  = 1'b0; // R12
                    end
                    default: begin
                        rdData_nxt = 16'h0000;
                    end
                endcase
            end
            // Other direct registers live outside this block and read zero here
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            func_r      <= 2'(`ACC_CTRL_RESET >> `FUNC_LSB);
            space_r     <= 5'(`ACC_CTRL_RESET & 16'h001f);
            rdData_r    <= 16'h0000;
            extWr_r     <= 1'b0;
            extRd_r     <= 1'b0;
            extWrData_r <= 16'h0000;
            extSpace_r  <= SPACE_PRIMARY;
            incDone_r   <= 1'b0;
        end else begin
            func_r      <= func_nxt;
            space_r     <= space_nxt;
            rdData_r    <= rdData_nxt;
            extWr_r     <= extWr_nxt;
            extRd_r     <= extRd_nxt;
            extWrData_r <= extWrData_nxt;
            extSpace_r  <= extSpace_nxt;
            incDone_r   <= incDone_nxt;
        end
    end

endmodule : mmd_indirect_register_access

`default_nettype wire

// ===== mgmt_station.sv
// Station model that drives management frames onto the serial pins
`timescale 1ns/1ns
`default_nettype none

module mgmt_station (
    input  wire logic core_clk,
    input  wire logic mdioLine,
    output var  logic mdc,
    output var  logic stOe,
    output var  logic stBit
);
    initial begin
        mdc   = 1'b0;
        stOe  = 1'b0;
        stBit = 1'b1;
    end

    // One bit: two cycles low with data set up, two cycles high
    task automatic bitCycle(input logic drive, input logic val, output logic seen);
        @(negedge core_clk);
        mdc   = 1'b0;
        stOe  = drive;
        stBit = val;
        repeat (2) @(negedge core_clk);
        mdc  = 1'b1;
        seen = mdioLine;
        @(negedge core_clk);
    endtask : bitCycle

    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] word;
        logic        seen;
        word = {2'h1, op, phy, rg, 2'h2, wd};
        rd   = 16'h0000;
        bitCycle(1'b1, 1'b1, seen);
        for (int i = 31; i >= 0; i--) begin
            // Read frames release the line from turnaround on
            bitCycle(op == 2'h1 || i > 17, word[i], seen);
            if (i < 16) rd[i] = seen;
        end
        // Clock stands still between frames, line left to the pull-up
        @(negedge core_clk);
        mdc  = 1'b0;
        stOe = 1'b0;
    endtask : xfer
endmodule : mgmt_station
`default_nettype wire

// ===== mmd_indirect_register_access_asserts.sv
// Port checker for the indirect extended register access block
`timescale 1ns/1ns
`default_nettype none

module mmd_indirect_register_access_asserts
    import mmd_access_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        mdc,
    input wire logic        mdioIn,
    input wire logic        mdioOut,
    input wire logic        mdioOe,
    input wire logic [4:0]  phyAddr,
    input wire space_e      extSpace,
    input wire logic [15:0] extAddr,
    input wire logic [15:0] extWrData,
    input wire logic        extWr,
    input wire logic        extRd,
    input wire logic [15:0] extRdData
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_WR_PULSE: assert property (extWr |=> !extWr)
        else $error("write strobe longer than one cycle");
    AST_RD_PULSE: assert property (extRd |=> !extRd)
        else $error("read strobe longer than one cycle");
    AST_NO_BOTH: assert property (!(extWr && extRd))
        else $error("read and write strobes together");
    AST_WR_TIMING: assert property (extWr |-> $past(mdc, 2) && !$past(mdc, 3))
        else $error("write strobe not two cycles after a clock rise");
    AST_RD_TIMING: assert property (extRd |-> $past(mdc, 2) && !$past(mdc, 3))
        else $error("read strobe not two cycles after a clock rise");
    AST_OUT_TIMING: assert property ($changed(mdioOut) |-> $past(mdc, 1) && !$past(mdc, 2))
        else $error("data pin changed off its slot");
    AST_TA_ZERO: assert property ($rose(mdioOe) |-> !mdioOut)
        else $error("turnaround not driven low");
    AST_OE_SPAN: assert property ($rose(mdioOe) |-> mdioOe [*8] ##[50:1000] !mdioOe)
        else $error("read drive window wrong length");
    AST_WR_QUIET: assert property (extWr |-> !mdioOe)
        else $error("pin driven during a write");
    AST_PTR_STEP: assert property ((extWr || extRd) |=>
        (extAddr == $past(extAddr)) || (extAddr == $past(extAddr) + 16'h0001))
        else $error("pointer moved by more than one");
endmodule : mmd_indirect_register_access_asserts

bind mmd_indirect_register_access mmd_indirect_register_access_asserts u_asserts (
    .core_clk(core_clk), .rstn(rstn), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddr(phyAddr), .extSpace(extSpace), .extAddr(extAddr),
    .extWrData(extWrData), .extWr(extWr), .extRd(extRd), .extRdData(extRdData));
`default_nettype wire

// ===== mmd_indirect_register_access_tb.sv
// Self-checking bench for the indirect extended register access block
`timescale 1ns/1ns
`default_nettype none

module mmd_indirect_register_access_tb
    import mmd_access_pkg::*;
;
    localparam logic [4:0] PHY = 5'h0c;
    localparam logic [4:0] CODES [6] = '{5'h1f, 5'h01, 5'h03, 5'h07, 5'h02, 5'h1e};
    logic        core_clk, rstn, mdc, mdioLine, stOe, stBit, mdioOut, mdioOe, extWr, extRd;
    logic [4:0]  phyAddr, mS;
    logic [15:0] extAddr, extWrData, extRdData, mP, skipRd;
    logic [1:0]  mF;
    logic [31:0] seed;
    logic [33:0] wq [$];
    space_e      extSpace;
    int          n_errors, check_count;

    // Stub register set: contents follow space and address
    function automatic logic [15:0] pat(input logic [1:0] sp, input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ {8{sp}};
    endfunction : pat

    assign extRdData = pat(extSpace, extAddr);
    // Pull-up holds the line when nobody drives
    assign mdioLine = mdioOe ? mdioOut : (stOe ? stBit : 1'b1);

    mmd_indirect_register_access dut (.core_clk(core_clk), .rstn(rstn), .mdc(mdc),
        .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(phyAddr),
        .extSpace(extSpace), .extAddr(extAddr), .extWrData(extWrData), .extWr(extWr),
        .extRd(extRd), .extRdData(extRdData));
    mgmt_station station (.core_clk(core_clk), .mdioLine(mdioLine), .mdc(mdc), .stOe(stOe),
        .stBit(stBit));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Model is updated before the frame, since strobes land inside it
    task automatic acc(input logic wr, input logic [4:0] rg, input logic [15:0] d,
                       input logic [4:0] ph);
        logic [15:0] rd;
        logic [15:0] exp;
        logic [1:0]  sp;
        logic        ok;
        exp = (ph == PHY) ? 16'h0000 : 16'hffff;
        ok  = (mS == 5'h1f) || (mS == 5'h01) || (mS == 5'h03) || (mS == 5'h07);
        sp  = (mS == 5'h01) ? 2'h1 : (mS == 5'h03) ? 2'h2 : (mS == 5'h07) ? 2'h3 : 2'h0;
        if (ph == PHY && rg == 5'h0d) begin
            if (wr) {mF, mS} = {d[15:14], d[4:0]};
            else exp = {mF, 9'h000, mS};
        end else if (ph == PHY && rg == 5'h0e && ok) begin
            if (mF == 2'h0 && wr) mP = d;
            else if (mF == 2'h0) exp = mP;
            else if (wr) wq.push_back({sp, mP, d});
            else exp = pat(sp, mP);
            if (mF == 2'h2 || (mF == 2'h3 && wr)) mP = mP + 16'h0001;
        end
        station.xfer(wr ? 2'h1 : 2'h2, ph, rg, d, rd);
        if (!wr) check("read data", {18'h0_0000, rd}, {18'h0_0000, exp});
    endtask : acc

    always @(posedge core_clk) begin
        if (rstn === 1'b1 && extWr === 1'b1) begin
            if (wq.size() == 0) wq.push_back({2'h3, 16'hffff, 16'hffff});
            check("ext write", {extSpace, extAddr, extWrData}, wq.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {rstn, mF, mS, mP} = '0;
        phyAddr     = PHY;
        seed        = 32'h4d44_03c6;
        n_errors    = 0;
        check_count = 0;
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        acc(1'b0, 5'h0d, 16'h0000, PHY);
        acc(1'b1, 5'h05, rnd(), PHY);
        acc(1'b0, 5'h05, 16'h0000, PHY);
        foreach (CODES[c]) begin
            for (int f = 0; f < 4; f++) begin
                // Reserved bits set on purpose, they must read back zero
                acc(1'b1, 5'h0d, {f[1:0], 9'h1ff, CODES[c]}, PHY);
                acc(1'b1, 5'h0e, rnd() & 16'h0fff, PHY);
                acc(1'b0, 5'h0e, 16'h0000, PHY);
                acc(1'b1, 5'h0e, rnd() & 16'h0fff, PHY);
                acc(1'b0, 5'h0e, 16'h0000, PHY);
                acc(1'b0, 5'h0d, 16'h0000, PHY);
            end
            acc(1'b1, 5'h0d, {11'h000, CODES[c]}, PHY);
            acc(1'b0, 5'h0e, 16'h0000, PHY);
        end
        // Pointer wraps from the top value on an incrementing write
        acc(1'b1, 5'h0d, 16'h001f, PHY);
        acc(1'b1, 5'h0e, 16'hffff, PHY);
        acc(1'b1, 5'h0d, 16'hc01f, PHY);
        acc(1'b1, 5'h0e, rnd(), PHY);
        acc(1'b1, 5'h0d, 16'h001f, PHY);
        acc(1'b0, 5'h0e, 16'h0000, PHY);
        // Frames for another station address are ignored
        acc(1'b1, 5'h0d, 16'h4001, PHY ^ 5'h01);
        acc(1'b0, 5'h0d, 16'h0000, PHY ^ 5'h01);
        // Frames with op codes 00 and 11 are counted out and change nothing
        station.xfer(2'h3, PHY, 5'h0d, 16'h8003, skipRd);
        station.xfer(2'h0, PHY, 5'h0d, 16'h8003, skipRd);
        acc(1'b0, 5'h0d, 16'h0000, PHY);
        repeat (10) @(negedge core_clk);
        check("pending writes", wq.size(), 34'h0_0000_0000);
        print_verdict();
    end
endmodule : mmd_indirect_register_access_tb
`default_nettype wire
